/* File: ssc_div_stage.sv */
// one channel divider stage: ratio decode and power gating
// assumes codes come from the serial register file
`timescale 1ns/1ps
module ssc_div_stage #(
  parameter bit FIRST = 1'b0
) (
  input  wire logic [2:0] code,     // ratio code
  input  wire logic       master,   // whole divider enabled
  input  wire logic       enable,   // this stage enabled
  input  wire logic       included, // stage is in the signal path
  output logic      [3:0] ratio,    // effective division of this stage
  output logic            powered   // stage powered up
);

  logic [3:0] raw;

  always_comb
  begin
    raw = 4'h1;
    if (FIRST)
      raw = code[0] ? 4'h3 : 4'h2;
    else
    begin
      unique case (code)
        3'h0:    raw = 4'h1;
        3'h1:    raw = 4'h2;
        3'h2:    raw = 4'h4;
        3'h3:    raw = 4'h6;
        3'h4:    raw = 4'h8;
        default: raw = 4'h1;
      endcase
    end
  end

  assign powered = master & enable & included;
  assign ratio   = included ? raw : 4'h1;

endmodule

/* File: ssc_host_model.sv */
// serial master model that sends frames and collects readback bits
// assumes the bench calls its tasks from one process
`timescale 1ns/1ps
module ssc_host_model (
  input  wire logic ref_clk,        // bench clock
  input  wire logic mux_output_pin, // readback line
  output logic      sclk,           // serial clock, still between frames except when stray toggles it
  output logic      sdi,            // serial data
  output logic      chip_select_n   // frame select, active low
);
  initial
  begin
    sclk = 1'b0;
    sdi = 1'b0;
    chip_select_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // sends the top nbits of word; rd takes bits at rising edges 9 to 24
  task automatic frame(input logic [23:0] word, input int nbits,
                       output logic [15:0] rd);
    rd = 16'h0000;
    @(posedge ref_clk);
    chip_select_n <= 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      sdi <= word[23-i];
      tick(4);
      sclk <= 1'b1;
      tick(1);
      if (i >= 8)
        rd[23-i] = mux_output_pin;
      tick(3);
      sclk <= 1'b0;
    end
    tick(4);
    chip_select_n <= 1'b1;
    sdi <= ~sdi; // released line shows no stale bit
    tick(8);
  endtask
  // clock edges with the device deselected
  task automatic stray(input int n);
    repeat (n)
    begin
      tick(4);
      sclk <= ~sclk;
    end
    tick(4);
  endtask
endmodule

/* File: ssc_pkg.sv */
// constants shared by the synthesizer serial control block
// assumes a single 100 MHz ref_clk domain; serial pins arrive unsynchronised
package ssc_pkg;

  // serial frame layout
  localparam int FRAME_BITS    = 24;
  localparam int ADDR_BITS     = 7;
  localparam int DATA_BITS     = 16;
  localparam int RW_POS        = 23;
  localparam int ADDR_MSB      = 22;
  localparam int ADDR_LSB      = 16;
  localparam int READ_LOAD_CNT = 7;   // count before the 8th rising edge
  localparam int CNT_BITS      = 5;

  // register addresses
  localparam logic [6:0] REG_CTRL      = 7'h00;
  localparam logic [6:0] REG_CHDIV     = 7'h23;
  localparam logic [6:0] REG_MODE      = 7'h24;
  localparam logic [6:0] REG_N_INT     = 7'h26;
  localparam logic [6:0] REG_DEN_LO    = 7'h28;
  localparam logic [6:0] REG_DEN_HI    = 7'h29;
  localparam logic [6:0] REG_SEED_LO   = 7'h2a;
  localparam logic [6:0] REG_SEED_HI   = 7'h2b;
  localparam logic [6:0] REG_NUM_LO    = 7'h2c;
  localparam logic [6:0] REG_NUM_HI    = 7'h2d;
  localparam logic [6:0] REG_OUTPUT    = 7'h2e;

  // control register fields
  localparam int CTRL_PWRDN_POS = 0;
  localparam int CTRL_RESET_POS = 1;
  localparam int CTRL_MUXSEL_POS = 2;
  localparam int CTRL_FCAL_POS  = 3;
  localparam int CTRL_LDEN_POS  = 13;
  localparam logic [15:0] CTRL_DEFAULT = 16'h0200;

  // channel divider register fields
  localparam int CHDIV_S1_LSB  = 0;
  localparam int CHDIV_S2_LSB  = 2;
  localparam int CHDIV_S3_LSB  = 5;
  localparam int CHDIV_SEL_LSB = 8;
  localparam int CHAN_DIV_MASTER_ENABLE_POS  = 10;
  localparam int CHDIV_S1_EN   = 11;
  localparam int CHDIV_S2_EN   = 12;
  localparam int CHDIV_S3_EN   = 13;
  localparam int CHDIV_DA_EN   = 14;
  localparam int CHDIV_D_EN    = 15;

  // stage selector codes
  localparam logic [1:0] SEL_ONE       = 2'h0;
  localparam logic [1:0] SEL_ONE_TWO   = 2'h1;

  // mode register fields
  localparam int MODE_PRE_POS  = 0;   // 0: prescaler 2, 1: prescaler 4
  localparam int MODE_FRAC_POS = 1;
  localparam logic [2:0] PRE_TWO  = 3'h2;
  localparam logic [2:0] PRE_FOUR = 3'h4;

  // integer divider field
  localparam int N_INT_LSB = 1;
  localparam int N_INT_BITS = 12;

  // output register fields
  localparam int OUT_A_SEL_POS = 0;
  localparam int OUT_B_SEL_POS = 1;
  localparam int OUT_A_POW_LSB = 2;
  localparam int OUT_B_POW_LSB = 8;
  localparam int POW_BITS      = 6;

  localparam logic [8:0] PHASE_FULL_TURN = 9'h168;   // 360 degrees

endpackage

/* File: ssc_serial_ctrl.sv */
// serial programming and control logic of a frequency synthesizer
// assumes all pin inputs are asynchronous to ref_clk and sclk runs
// well below a quarter of the ref_clk rate
`timescale 1ns/1ps

module ssc_serial_ctrl #(
  parameter int DEPTH = 128
) (
  input  wire logic        ref_clk,                // system clock, 100 MHz
  input  wire logic        rst,                    // sync reset, active high
  input  wire logic        sclk,                   // serial clock pin
  input  wire logic        sdi,                    // serial data pin
  input  wire logic        chip_select_n,          // frame select, active low
  input  wire logic        chip_enable,            // chip enable pin
  input  wire logic        pll_locked,             // lock status from loop
  output logic             mux_output_pin,         // lock or readback
  output logic             freq_cal_trigger,       // calibration start pulse
  output logic             power_down,             // device powered down
  output logic             phase_shift_pulse,      // seed phase step pulse
  output logic      [43:0] phase_shift_num,        // 360*seed*prescaler
  output logic      [39:0] phase_shift_den,        // denominator*division
  output logic      [3:0]  chan_div_stage_one,     // stage one ratio
  output logic      [3:0]  chan_div_stage_two,     // stage two ratio
  output logic      [3:0]  chan_div_stage_three,   // stage three ratio
  output logic      [7:0]  chan_div_total,         // total division
  output logic             chan_div_master_enable, // divider powered
  output logic      [2:0]  stage_power,            // per stage power
  output logic             dist_buffer_a_enable,   // distribution buffer A
  output logic             dist_buffer_enable,     // distribution buffer
  output logic             out_a_divided,          // A takes divider output
  output logic             out_b_divided,          // B takes divider output
  output logic      [5:0]  out_a_power_level,      // output A drive
  output logic      [5:0]  out_b_power_level,      // output B drive
  output logic      [11:0] n_divider,              // integer N divider
  output logic      [31:0] frac_numerator,         // fractional numerator
  output logic      [31:0] frac_denominator        // fractional denominator
);

  if (DEPTH < 64 || DEPTH > 128)
    $error("DEPTH must lie between 64 and 128");

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation and edge detection

  logic [4:0] pins_sync;
  logic       sclk_s;
  logic       sdi_s;
  logic       csn_s;
  logic       ce_s;
  logic       cs_s;
  logic       pd_req_s;
  logic       lock_s;
  logic       sclk_d_reg;
  logic       csn_d_reg;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_rise;

  ssc_sync #(
    .WIDTH (5)
  ) u_sync (
    .clk      (ref_clk),
    .rst      (rst),
    .async_in ({pll_locked, ~chip_enable, ~chip_select_n, sdi, sclk}),
    .sync_out (pins_sync)
  );

  assign {lock_s, pd_req_s, cs_s, sdi_s, sclk_s} = pins_sync;
  assign csn_s = ~cs_s;
  assign ce_s  = ~pd_req_s;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sclk_d_reg <= 1'b0;
      csn_d_reg  <= 1'b1;
    end
    else
    begin
      sclk_d_reg <= sclk_s;
      csn_d_reg  <= csn_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d_reg & ~csn_s;
  assign sclk_fall = ~sclk_s & sclk_d_reg & ~csn_s;
  assign cs_rise   = csn_s & ~csn_d_reg;

  ////////////////////////////////////////////////////////////////////////////
  // frame shift register

  logic [ssc_pkg::FRAME_BITS-1:0] shift_reg;
  logic [ssc_pkg::CNT_BITS-1:0]   bit_cnt_reg;
  logic                           frame_ok;
  logic                           wr_frame;
  logic [ssc_pkg::ADDR_BITS-1:0]  wr_addr;
  logic [ssc_pkg::DATA_BITS-1:0]  wr_data;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      shift_reg   <= '0;
      bit_cnt_reg <= '0;
    end
    else if (csn_s & csn_d_reg)
      bit_cnt_reg <= '0;
    else if (sclk_rise)
    begin
      shift_reg <= {shift_reg[ssc_pkg::FRAME_BITS-2:0], sdi_s};
      if (bit_cnt_reg != ssc_pkg::CNT_BITS'(ssc_pkg::FRAME_BITS + 1))
        bit_cnt_reg <= bit_cnt_reg + 1'b1;
    end
  end

  // exactly 24 bits must have arrived, otherwise the frame is dropped
  assign frame_ok = cs_rise &&
    bit_cnt_reg == ssc_pkg::CNT_BITS'(ssc_pkg::FRAME_BITS);
  assign wr_frame = frame_ok & ~shift_reg[ssc_pkg::RW_POS];
  assign wr_addr  = shift_reg[ssc_pkg::ADDR_MSB:ssc_pkg::ADDR_LSB];
  assign wr_data  = shift_reg[ssc_pkg::DATA_BITS-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // register file

  logic [ssc_pkg::DATA_BITS-1:0] regs [DEPTH];
  logic                          soft_reset;

  assign soft_reset = wr_frame && wr_addr == ssc_pkg::REG_CTRL &&
                      wr_data[ssc_pkg::CTRL_RESET_POS];

  always_ff @(posedge ref_clk)
  begin
    if (rst || soft_reset)
    begin
      for (int i = 0; i < DEPTH; i++)
        regs[i] <= '0;
      regs[ssc_pkg::REG_CTRL] <= ssc_pkg::CTRL_DEFAULT;
    end
    else if (wr_frame)
      regs[wr_addr] <= wr_data;
  end

  logic [15:0] ctrl;
  logic [15:0] chdiv;
  logic [15:0] mode;
  logic [15:0] outcfg;
  logic [31:0] seed;
  logic [31:0] den;

  assign ctrl   = regs[ssc_pkg::REG_CTRL];
  assign chdiv  = regs[ssc_pkg::REG_CHDIV];
  assign mode   = regs[ssc_pkg::REG_MODE];
  assign outcfg = regs[ssc_pkg::REG_OUTPUT];
  assign seed   = {regs[ssc_pkg::REG_SEED_HI], regs[ssc_pkg::REG_SEED_LO]};
  assign den    = {regs[ssc_pkg::REG_DEN_HI], regs[ssc_pkg::REG_DEN_LO]};

  ////////////////////////////////////////////////////////////////////////////
  // readback shifter

  logic [15:0] rd_shift_reg;
  logic        rd_active_reg;
  logic        rd_bit_reg;
  logic [6:0]  rd_addr;

  assign rd_addr = {shift_reg[5:0], sdi_s};

  always_ff @(posedge ref_clk)
  begin
    if (rst || csn_s)
    begin
      rd_shift_reg  <= '0;
      rd_active_reg <= 1'b0;
      rd_bit_reg    <= 1'b0;
    end
    else if (sclk_rise &&
             bit_cnt_reg == ssc_pkg::CNT_BITS'(ssc_pkg::READ_LOAD_CNT))
    begin
      rd_active_reg <= shift_reg[6];
      rd_shift_reg  <= (int'(rd_addr) < DEPTH) ? regs[rd_addr] : '0;
    end
    else if (sclk_fall && rd_active_reg)
    begin
      rd_bit_reg   <= rd_shift_reg[15];
      rd_shift_reg <= {rd_shift_reg[14:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power down, calibration and multiplexed pin

  logic pd_now;

  assign pd_now = ~ce_s | ctrl[ssc_pkg::CTRL_PWRDN_POS];

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      power_down       <= 1'b0;
      freq_cal_trigger <= 1'b0;
    end
    else
    begin
      power_down       <= pd_now;
      freq_cal_trigger <= wr_frame && wr_addr == ssc_pkg::REG_CTRL &&
                          wr_data[ssc_pkg::CTRL_FCAL_POS] &&
                          !wr_data[ssc_pkg::CTRL_RESET_POS] && !pd_now;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      mux_output_pin <= 1'b0;
    else if (ctrl[ssc_pkg::CTRL_MUXSEL_POS])
      mux_output_pin <= ctrl[ssc_pkg::CTRL_LDEN_POS] & lock_s;
    else
      mux_output_pin <= rd_active_reg & rd_bit_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel divider and outputs

  logic [3:0] ratio [3];
  logic [2:0] powered;
  logic [2:0] included;
  logic [2:0] stage_en;
  logic [2:0] code [3];
  logic [1:0] sel;

  assign sel         = chdiv[ssc_pkg::CHDIV_SEL_LSB +: 2];
  assign included[0] = 1'b1;
  assign included[1] = sel != ssc_pkg::SEL_ONE;
  assign included[2] = sel != ssc_pkg::SEL_ONE && sel != ssc_pkg::SEL_ONE_TWO;
  assign stage_en    = {chdiv[ssc_pkg::CHDIV_S3_EN], chdiv[ssc_pkg::CHDIV_S2_EN],
                        chdiv[ssc_pkg::CHDIV_S1_EN]};
  assign code[0]     = {2'h0, chdiv[ssc_pkg::CHDIV_S1_LSB]};
  assign code[1]     = chdiv[ssc_pkg::CHDIV_S2_LSB +: 3];
  assign code[2]     = chdiv[ssc_pkg::CHDIV_S3_LSB +: 3];

  for (genvar g = 0; g < 3; g++)
  begin : g_stage
    ssc_div_stage #(
      .FIRST (g == 0)
    ) u_stage (
      .code     (code[g]),
      .master   (chdiv[ssc_pkg::CHAN_DIV_MASTER_ENABLE_POS]),
      .enable   (stage_en[g]),
      .included (included[g]),
      .ratio    (ratio[g]),
      .powered  (powered[g])
    );
  end

  logic [7:0] total;

  assign total = 8'(ratio[0]) * 8'(ratio[1]) * 8'(ratio[2]);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      chan_div_stage_one     <= 4'h2;
      chan_div_stage_two     <= 4'h1;
      chan_div_stage_three   <= 4'h1;
      chan_div_total         <= 8'h02;
      chan_div_master_enable <= 1'b0;
      stage_power            <= 3'h0;
      dist_buffer_a_enable   <= 1'b0;
      dist_buffer_enable     <= 1'b0;
      out_a_divided          <= 1'b0;
      out_b_divided          <= 1'b0;
      out_a_power_level      <= 6'h00;
      out_b_power_level      <= 6'h00;
      n_divider              <= 12'h000;
      frac_numerator         <= 32'h0;
      frac_denominator       <= 32'h0;
    end
    else
    begin
      chan_div_stage_one     <= ratio[0];
      chan_div_stage_two     <= ratio[1];
      chan_div_stage_three   <= ratio[2];
      chan_div_total         <= total;
      chan_div_master_enable <= chdiv[ssc_pkg::CHAN_DIV_MASTER_ENABLE_POS];
      stage_power            <= powered;
      dist_buffer_a_enable   <= chdiv[ssc_pkg::CHDIV_DA_EN];
      dist_buffer_enable     <= chdiv[ssc_pkg::CHDIV_D_EN];
      out_a_divided          <= outcfg[ssc_pkg::OUT_A_SEL_POS];
      out_b_divided          <= outcfg[ssc_pkg::OUT_B_SEL_POS];
      out_a_power_level <= outcfg[ssc_pkg::OUT_A_POW_LSB +: ssc_pkg::POW_BITS];
      out_b_power_level <= outcfg[ssc_pkg::OUT_B_POW_LSB +: ssc_pkg::POW_BITS];
      n_divider <= regs[ssc_pkg::REG_N_INT][ssc_pkg::N_INT_LSB +: ssc_pkg::N_INT_BITS];
      frac_numerator   <= {regs[ssc_pkg::REG_NUM_HI], regs[ssc_pkg::REG_NUM_LO]};
      frac_denominator <= den;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase adjust: step terms follow the seed, pulse marks each seed write made in fractional mode

  logic [2:0] pre;
  logic       seed_wr_reg;

  assign pre = mode[ssc_pkg::MODE_PRE_POS] ? ssc_pkg::PRE_FOUR
                                           : ssc_pkg::PRE_TWO;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      seed_wr_reg       <= 1'b0;
      phase_shift_pulse <= 1'b0;
      phase_shift_num   <= 44'h0;
      phase_shift_den   <= 40'h0;
    end
    else
    begin
      seed_wr_reg <= wr_frame && !soft_reset &&
                     mode[ssc_pkg::MODE_FRAC_POS] &&
                     (wr_addr == ssc_pkg::REG_SEED_LO ||
                      wr_addr == ssc_pkg::REG_SEED_HI);
      phase_shift_pulse <= seed_wr_reg;
      phase_shift_num   <= 44'(44'(seed) * 44'(pre) *
                               44'(ssc_pkg::PHASE_FULL_TURN));
      phase_shift_den   <= 40'(40'(den) * 40'(chan_div_total));
    end
  end

endmodule

/* File: ssc_serial_ctrl_monitor.sv */
// concurrent checks on the ports of the serial control block
// assumes it is bound onto every ssc_serial_ctrl instance
`timescale 1ns/1ps
module ssc_serial_ctrl_monitor (
  input wire logic       ref_clk,                // system clock
  input wire logic       rst,                    // sync reset
  input wire logic       chip_select_n,          // frame select
  input wire logic       chip_enable,            // chip enable pin
  input wire logic       freq_cal_trigger,       // calibration pulse
  input wire logic       power_down,             // powered down
  input wire logic       phase_shift_pulse,      // phase step pulse
  input wire logic [3:0] chan_div_stage_one,     // stage one ratio
  input wire logic [3:0] chan_div_stage_two,     // stage two ratio
  input wire logic [3:0] chan_div_stage_three,   // stage three ratio
  input wire logic [7:0] chan_div_total,         // total division
  input wire logic       chan_div_master_enable, // divider powered
  input wire logic [2:0] stage_power,            // per stage power
  input wire logic [5:0] out_a_power_level,      // output A drive
  input wire logic [11:0] n_divider              // integer divider
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_ce_low;
    !chip_enable [*4];
  endsequence
  sequence s_quiet;
    ($stable(chan_div_stage_one) && $stable(chan_div_stage_two)
      && $stable(chan_div_stage_three)) [*2];
  endsequence

  property p_stage_one;
    chan_div_stage_one == 4'h2 || chan_div_stage_one == 4'h3;
  endproperty
  property p_total_range;
    chan_div_total >= 8'h02 && chan_div_total <= 8'hc0;
  endproperty
  property p_total_product;
    s_quiet |-> {4'h0, chan_div_total} ==
      chan_div_stage_one * chan_div_stage_two * chan_div_stage_three;
  endproperty
  property p_cal_pulse;
    freq_cal_trigger |=> !freq_cal_trigger;
  endproperty
  property p_cal_powered;
    freq_cal_trigger |-> !power_down;
  endproperty
  property p_cal_after_frame;
    freq_cal_trigger |-> chip_select_n && $past(chip_select_n, 3);
  endproperty
  property p_ce_down;
    s_ce_low |-> power_down;
  endproperty
  property p_phase_pulse;
    phase_shift_pulse |=> !phase_shift_pulse;
  endproperty
  property p_cfg_hold;
    ($changed(out_a_power_level) || $changed(n_divider)) |-> chip_select_n;
  endproperty
  property p_master_off;
    !chan_div_master_enable |-> stage_power == 3'h0;
  endproperty

  a_stage_one: assert property (p_stage_one)
    else $error("stage one ratio outside 2 or 3");
  a_total_range: assert property (p_total_range)
    else $error("total division outside 2 to 192");
  a_total_product: assert property (p_total_product)
    else $error("total division is not the stage product");
  a_cal_pulse: assert property (p_cal_pulse)
    else $error("calibration pulse longer than one cycle");
  a_cal_powered: assert property (p_cal_powered)
    else $error("calibration started while powered down");
  a_cal_after_frame: assert property (p_cal_after_frame)
    else $error("calibration not after a completed frame");
  a_ce_down: assert property (p_ce_down)
    else $error("chip enable low without power down");
  a_phase_pulse: assert property (p_phase_pulse)
    else $error("phase pulse longer than one cycle");
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("configuration changed inside a frame");
  a_master_off: assert property (p_master_off)
    else $error("stage powered with divider disabled");
endmodule

bind ssc_serial_ctrl ssc_serial_ctrl_monitor i_mon (.ref_clk, .rst,
  .chip_select_n, .chip_enable, .freq_cal_trigger, .power_down,
  .phase_shift_pulse, .chan_div_stage_one, .chan_div_stage_two,
  .chan_div_stage_three, .chan_div_total, .chan_div_master_enable,
  .stage_power, .out_a_power_level, .n_divider);

/* File: ssc_sync.sv */
// two flip-flop synchroniser for a group of independent level inputs
// assumes each bit changes slowly relative to clk
`timescale 1ns/1ps
module ssc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,     // sampling clock
  input  wire logic             rst,     // synchronous reset, active high
  input  wire logic [WIDTH-1:0] async_in, // unsynchronised levels
  output logic      [WIDTH-1:0] sync_out  // levels in clk domain
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

/* File: test_ssc_serial_ctrl.sv */
// self-checking bench for the serial control block
// assumes ssc_host_model drives every frame on the serial pins
`timescale 1ns/1ps
module test_ssc_serial_ctrl;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        chip_enable = 1'b1;
  logic        pll_locked = 1'b0;
  logic        sclk, sdi, chip_select_n, mux_output_pin;
  logic        freq_cal_trigger, power_down, phase_shift_pulse;
  logic [43:0] phase_shift_num, ph_num;
  logic [39:0] phase_shift_den, ph_den;
  logic [3:0]  chan_div_stage_one, chan_div_stage_two, chan_div_stage_three;
  logic [7:0]  chan_div_total;
  logic        chan_div_master_enable, dist_buffer_a_enable;
  logic        dist_buffer_enable, out_a_divided, out_b_divided;
  logic [2:0]  stage_power;
  logic [5:0]  out_a_power_level, out_b_power_level;
  logic [11:0] n_divider;
  logic [31:0] frac_numerator, frac_denominator;
  logic [15:0] q;
  logic [15:0] dv [5] = '{16'hfe91, 16'h004c, 16'h7d8d, 16'h0364, 16'h021c};
  logic [11:0] sv [5] = '{12'h388, 12'h211, 12'h361, 12'h226, 12'h211};
  logic [7:0]  tv [5] = '{8'hc0, 8'h02, 8'h12, 8'h18, 8'h02};
  logic [15:0] ov [2] = '{16'h15a9, 16'h00fe};
  int          failures = 0, n_tests = 0, cycles = 0, n_cal = 0, n_ph = 0;

  always #5 ref_clk = ~ref_clk;

  ssc_serial_ctrl i_dut (.ref_clk, .rst, .sclk, .sdi, .chip_select_n,
    .chip_enable, .pll_locked, .mux_output_pin, .freq_cal_trigger,
    .power_down, .phase_shift_pulse, .phase_shift_num, .phase_shift_den,
    .chan_div_stage_one, .chan_div_stage_two, .chan_div_stage_three,
    .chan_div_total, .chan_div_master_enable, .stage_power,
    .dist_buffer_a_enable, .dist_buffer_enable, .out_a_divided,
    .out_b_divided, .out_a_power_level, .out_b_power_level, .n_divider,
    .frac_numerator, .frac_denominator);
  ssc_host_model i_host (.ref_clk, .mux_output_pin, .sclk, .sdi,
    .chip_select_n);

  //////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [43:0] got, input logic [43:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] x;
    i_host.frame({1'b0, a, d}, 24, x);
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] v);
    i_host.frame({1'b1, a, 16'hffff}, 24, v);
  endtask

  always @(posedge ref_clk)
  begin
    cycles++;
    if (freq_cal_trigger === 1'b1)
      n_cal++;
    if (phase_shift_pulse === 1'b1)
    begin
      n_ph++;
      ph_num = phase_shift_num;
      ph_den = phase_shift_den;
    end
    if (cycles == 30000)
    begin
      failures++;
      final_report();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk(chan_div_total, 8'h02);
    rd(ssc_pkg::REG_CTRL, q);
    chk(q, 16'h0200);
    chk(power_down, 1'b0);
    for (int k = 0; k < 5; k++)
    begin
      wr(ssc_pkg::REG_CHDIV, dv[k]);
      chk({chan_div_stage_one, chan_div_stage_two, chan_div_stage_three},
          sv[k]);
      chk(chan_div_total, tv[k]);
      chk({dist_buffer_enable, dist_buffer_a_enable, chan_div_master_enable},
          {dv[k][15], dv[k][14], dv[k][10]});
      if (k == 0)
        chk(stage_power, 3'h7);
    end
    for (int k = 0; k < 2; k++)
    begin
      wr(ssc_pkg::REG_OUTPUT, ov[k]);
      chk({out_b_divided, out_a_divided}, ov[k][1:0]);
      chk({out_b_power_level, out_a_power_level}, ov[k][13:2]);
    end
    i_host.frame({1'b0, ssc_pkg::REG_OUTPUT, 16'hffff}, 16, q);
    i_host.stray(6);
    rd(ssc_pkg::REG_OUTPUT, q);
    chk(q, 16'h00fe);
    wr(ssc_pkg::REG_N_INT, 16'h014a);
    wr(ssc_pkg::REG_DEN_LO, 16'h0064);
    wr(ssc_pkg::REG_DEN_HI, 16'h0001);
    wr(ssc_pkg::REG_NUM_LO, 16'h1234);
    wr(ssc_pkg::REG_NUM_HI, 16'h0000);
    chk({n_divider, frac_numerator, frac_denominator},
        {12'h0a5, 32'h00001234, 32'h00010064});
    wr(ssc_pkg::REG_MODE, 16'h0003);
    wr(ssc_pkg::REG_SEED_LO, 16'h0005);
    chk(n_ph, 1);
    chk({ph_num, ph_den}, {44'd7200, 40'h00000200c8});
    wr(ssc_pkg::REG_MODE, 16'h0002);
    wr(ssc_pkg::REG_SEED_HI, 16'h0000);
    chk({n_ph[3:0], ph_num}, {4'h2, 44'd3600});
    wr(ssc_pkg::REG_MODE, 16'h0000);
    wr(ssc_pkg::REG_SEED_LO, 16'h0005);
    chk(n_ph, 2);
    wr(ssc_pkg::REG_CTRL, 16'h2208);
    chk(n_cal, 1);
    wr(ssc_pkg::REG_CTRL, 16'h2200);
    chk(n_cal, 1);
    wr(ssc_pkg::REG_CTRL, 16'h2209);
    chk({n_cal[3:0], power_down}, {4'h2, 1'b1});
    wr(ssc_pkg::REG_CTRL, 16'h2200);
    chk(power_down, 1'b0);
    wr(ssc_pkg::REG_CTRL, 16'h2208);
    chk(n_cal, 3);
    chip_enable <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk(power_down, 1'b1);
    wr(ssc_pkg::REG_CTRL, 16'h2208);
    chk(n_cal, 3);
    chip_enable <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk(power_down, 1'b0);
    wr(ssc_pkg::REG_CTRL, 16'h2208);
    chk(n_cal, 4);
    wr(ssc_pkg::REG_CTRL, 16'h2204);
    pll_locked <= 1'b1;
    repeat (5) @(posedge ref_clk);
    chk(mux_output_pin, 1'b1);
    pll_locked <= 1'b0;
    repeat (5) @(posedge ref_clk);
    chk(mux_output_pin, 1'b0);
    wr(ssc_pkg::REG_CTRL, 16'h000a);
    chk(n_cal, 4);
    chk({out_a_power_level, n_divider}, 18'h00000);
    rd(ssc_pkg::REG_CTRL, q);
    chk(q, 16'h0200);
    final_report();
  end
endmodule
